// File: rtl/sfwc_top.sv
// Purpose: write enable control, status protection and identification for a serial flash
// Assumes: SPI modes 0 and 3; the serial clock is quiet while chip enable is high
// Notes: commands take effect when the core sees chip enable rise after the frame
// Behaviour
// - write enable command sets the latch
// - program needs latch set, else refused
// - latch also allows status write, then clears
// - write enable acts only at frame end
// - write disable clears latch and auto-increment bit
// - write disable never stops a running program
// - arm command opens the next status write
// - arm takes effect at the frame end
// - status write changes protect and lock bits, and clears the latch
// - status write ignored when pin low, lock set
// - pin low: lock may rise, never fall
// - pin high: lock and protect bits freely written
// - lock checked at frame end, one write suffices
// - standard ident sends maker, type, capacity bytes
// - chip enable rise ends ident output at once
// - legacy ident accepts two opcodes plus address
// - legacy ident: address zero maker, one device
// - legacy ident alternates bytes until frame ends
// - write disable is one opcode byte only
// - opcode eight bits MSB first, address 24 bits
`timescale 1ns/100ps
module sfwc_top
  import sfwc_pkg::*;
#(
  parameter logic [7:0] OP_WRITE_ENABLE = OP_WRITE_ENABLE_DEF,
  parameter logic [7:0] OP_ARM_STATUS = OP_ARM_STATUS_DEF,
  parameter logic [7:0] OP_STATUS_WRITE = OP_STATUS_WRITE_DEF,
  parameter sfwc_ident_t IDENT = 24'h5a3c17, // Arbitrary values
  parameter int PROG_CYCLES = BP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sck_clk,
  input wire logic ce_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic prog_req,
  input wire logic auto_inc_start,
  output logic so,
  output logic so_oe,
  output logic prog_grant,
  output sfwc_status_t status
);
  // Link side state
  logic [5:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] op_reg;
  logic [7:0] dat_reg;
  logic op_done_reg;
  logic dat_done_reg;
  logic addr_lsb_reg;
  logic link_clr;
  sfwc_out_t mode_reg;
  logic [2:0] out_bit_reg;
  logic [1:0] out_byte_reg;
  logic so_reg;
  logic so_oe_reg;
  logic [7:0] std_first;
  logic [7:0] leg_first;
  logic [7:0] cur_byte;
  // Core side state
  logic [1:0] pin_s;
  logic ce_s;
  logic wp_s;
  logic ce_prev_reg;
  logic clr_reg;
  logic exec;
  logic cmd_wr_en;
  logic cmd_wr_dis;
  logic cmd_arm;
  logic cmd_st_write;
  logic st_write_open;
  logic lock_free;
  logic wel_reg;
  logic auto_inc_reg;
  logic arm_reg;
  logic lock_reg;
  logic [3:0] protect_reg;
  logic grant_reg;
  logic busy;

  if (PROG_CYCLES < 1) begin : g_chk_cycles
    $error("sfwc_top program time must be at least one cycle");
  end
  if ((OP_WRITE_ENABLE == OP_ARM_STATUS) || (OP_WRITE_ENABLE == OP_STATUS_WRITE) ||
      (OP_ARM_STATUS == OP_STATUS_WRITE)) begin : g_chk_ops
    $error("sfwc_top opcodes must differ");
  end

  // Byte sent at a given index of an ident sequence
  function automatic logic [7:0] ident_byte(input sfwc_out_t m, input logic [1:0] idx,
                                            input logic lsb);
    logic [7:0] b;
    b = 8'h00;
    if (m == SFWC_OUT_STD) begin
      case (idx)
        2'h0: b = IDENT.mfr;
        2'h1: b = IDENT.mem_type;
        2'h2: b = IDENT.capacity;
        default: b = 8'h00; // Past the third byte
      endcase
    end else if (m == SFWC_OUT_LEG) begin
      b = ((lsb ^ idx[0]) == ID_ADDR_DEV[0]) ? IDENT.capacity : IDENT.mfr;
    end
    return b;
  endfunction

  // Bit counter and input shifter, cleared by the frame itself
  always_ff @(posedge sck_clk or posedge ce_n) begin
    if (ce_n) begin
      bit_cnt_reg <= 6'h00;
      shift_reg <= 8'h00;
    end else begin
      shift_reg <= {shift_reg[6:0], si};
      if (bit_cnt_reg != CNT_LEG_START) begin
        bit_cnt_reg <= bit_cnt_reg + CNT_STEP;
      end
    end
  end

  // Captured words must outlive the frame, so the core clears them after it read them
  assign link_clr = ce_n & clr_reg;

  // Opcode, data byte and address low bit capture
  always_ff @(posedge sck_clk or posedge link_clr) begin
    if (link_clr) begin
      op_reg <= 8'h00;
      op_done_reg <= 1'b0;
      dat_reg <= 8'h00;
      dat_done_reg <= 1'b0;
      addr_lsb_reg <= 1'b0;
    end else begin
      if (bit_cnt_reg == CNT_OPCODE_LAST) begin
        op_reg <= {shift_reg[6:0], si};
        op_done_reg <= 1'b1;
      end
      if (bit_cnt_reg == CNT_DATA_LAST) begin
        dat_reg <= {shift_reg[6:0], si};
        dat_done_reg <= 1'b1;
      end
      if (bit_cnt_reg == CNT_ADDR_LAST) begin
        addr_lsb_reg <= si;
      end
    end
  end

  // First bytes and the byte in flight
  always_comb begin
    std_first = ident_byte(SFWC_OUT_STD, 2'h0, addr_lsb_reg);
    leg_first = ident_byte(SFWC_OUT_LEG, 2'h0, addr_lsb_reg);
    cur_byte = ident_byte(mode_reg, out_byte_reg, addr_lsb_reg);
  end

  // Output sequencer on the falling edge; chip enable high stops it at once
  always_ff @(negedge sck_clk or posedge ce_n) begin
    if (ce_n) begin
      mode_reg <= SFWC_OUT_IDLE;
      out_bit_reg <= 3'h0;
      out_byte_reg <= 2'h0;
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
    end else begin
      case (mode_reg)
        SFWC_OUT_IDLE: begin
          if ((bit_cnt_reg == CNT_STD_START) && sfwc_is_std(op_reg)) begin
            mode_reg <= SFWC_OUT_STD;
            so_oe_reg <= 1'b1;
            so_reg <= std_first[7];
            out_bit_reg <= 3'h1;
          end else if ((bit_cnt_reg == CNT_LEG_START) && sfwc_is_legacy(op_reg)) begin
            mode_reg <= SFWC_OUT_LEG;
            so_oe_reg <= 1'b1;
            so_reg <= leg_first[7];
            out_bit_reg <= 3'h1;
          end
        end
        SFWC_OUT_STD, SFWC_OUT_LEG: begin
          so_reg <= cur_byte[3'h7 - out_bit_reg];
          out_bit_reg <= out_bit_reg + 3'h1;
          if (out_bit_reg == 3'h7) begin
            if (mode_reg == SFWC_OUT_LEG) begin
              out_byte_reg <= {1'b0, ~out_byte_reg[0]};
            end else if (out_byte_reg != 2'h3) begin
              out_byte_reg <= out_byte_reg + 2'h1;
            end
          end
        end
        default: begin
          mode_reg <= SFWC_OUT_IDLE;
        end
      endcase
    end
  end

  assign so = so_reg;
  assign so_oe = so_oe_reg;

  // Chip enable and write protect pins into the core domain
  sfwc_sync #(.WIDTH(2), .RST_VAL(PIN_SYNC_RESET)) u_pin_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .din({ce_n, wp_n}),
    .dout(pin_s)
  );
  assign ce_s = pin_s[1];
  assign wp_s = pin_s[0];

  // Frame end detection; captured words are stable since the serial clock is quiet
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ce_prev_reg <= 1'b1;
    end else begin
      ce_prev_reg <= ce_s;
    end
  end

  // Clear request for the captured words, dropped while a frame runs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clr_reg <= 1'b1;
    end else if (!ce_s) begin
      clr_reg <= 1'b0;
    end else if (!ce_prev_reg) begin
      clr_reg <= 1'b1;
    end
  end

  // Command decode at the frame end only
  assign exec = ce_s & ~ce_prev_reg & op_done_reg;
  assign cmd_wr_en = exec && (op_reg == OP_WRITE_ENABLE);
  assign cmd_wr_dis = exec && (op_reg == OP_WRITE_DISABLE);
  assign cmd_arm = exec && (op_reg == OP_ARM_STATUS);
  assign cmd_st_write = exec && (op_reg == OP_STATUS_WRITE) && dat_done_reg;
  assign st_write_open = arm_reg | wel_reg;
  assign lock_free = wp_s | ~lock_reg;

  // Write enable latch
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wel_reg <= 1'b0;
    end else if (cmd_wr_en) begin
      wel_reg <= 1'b1;
    end else if (cmd_wr_dis || cmd_st_write) begin
      wel_reg <= 1'b0;
    end
  end

  // Auto-increment bit; a start in the same cycle as a disable wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      auto_inc_reg <= 1'b0;
    end else if (auto_inc_start && wel_reg) begin
      auto_inc_reg <= 1'b1;
    end else if (cmd_wr_dis) begin
      auto_inc_reg <= 1'b0;
    end
  end

  // Arming lasts for exactly one following command
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      arm_reg <= 1'b0;
    end else if (exec) begin
      arm_reg <= cmd_arm;
    end
  end

  // Protect and lock bits
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
      protect_reg <= 4'h0;
    end else if (cmd_st_write && st_write_open && lock_free) begin
      lock_reg <= dat_reg[SR_LOCK_POS];
      protect_reg <= dat_reg[SR_BP_MSB:SR_BP_LSB];
    end
  end

  // Program grant; only the latch and an idle array allow it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      grant_reg <= 1'b0;
    end else begin
      grant_reg <= prog_req && wel_reg && !busy;
    end
  end
  assign prog_grant = grant_reg;

  // Program timer is not touched by write disable
  sfwc_prog_timer #(.CYCLES(PROG_CYCLES)) u_prog_timer (
    .clk(core_clk),
    .rst_n(rst_n),
    .start(grant_reg),
    .busy(busy)
  );

  // Status view
  always_comb begin
    status.lock = lock_reg;
    status.protect = protect_reg;
    status.auto_inc = auto_inc_reg;
    status.wel = wel_reg;
    status.busy = busy;
  end

  // Checks on the core side
  wel_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_wr_en |=> wel_reg ##1 wel_reg || $past(cmd_wr_dis) || $past(cmd_st_write))
    else $error("latch not set by write enable");
  wel_frame_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !exec |=> $stable(wel_reg))
    else $error("latch moved outside a frame end");
  grant_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    prog_grant |-> $past(wel_reg) && $past(prog_req))
    else $error("program granted without latch");
  latch_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_st_write |=> !wel_reg)
    else $error("latch kept after status write");
  disable_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_wr_dis && !auto_inc_start |=> !wel_reg && !auto_inc_reg)
    else $error("write disable left bits set");
  busy_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy && cmd_wr_dis |=> busy)
    else $error("write disable ended a program");
  arm_next_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    exec && !cmd_arm |=> !arm_reg)
    else $error("arming survived another command");
  arm_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_arm |=> arm_reg)
    else $error("arm command not taken");
  lock_ignore_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_st_write && !wp_s && lock_reg |=> $stable(protect_reg) && lock_reg)
    else $error("locked status was written");
  lock_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wp_s && lock_reg |=> lock_reg)
    else $error("lock cleared with pin low");
  free_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_st_write && st_write_open && wp_s |=>
      protect_reg == $past(dat_reg[SR_BP_MSB:SR_BP_LSB]) &&
      lock_reg == $past(dat_reg[SR_LOCK_POS]))
    else $error("status write not applied");

  // Checks on the link side
  std_first_a: assert property (@(negedge sck_clk) disable iff (ce_n)
    $rose(so_oe_reg) && mode_reg == SFWC_OUT_STD |-> so_reg == IDENT.mfr[7])
    else $error("standard ident did not start with maker");
  leg_first_a: assert property (@(negedge sck_clk) disable iff (ce_n)
    $rose(so_oe_reg) && mode_reg == SFWC_OUT_LEG |->
      so_reg == ((addr_lsb_reg == ID_ADDR_DEV[0]) ? IDENT.capacity[7] : IDENT.mfr[7]))
    else $error("legacy ident started with wrong byte");

  wel_set_c: cover property (@(posedge core_clk) disable iff (!rst_n) cmd_wr_en);
  st_write_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    cmd_st_write && st_write_open && lock_free);
  std_out_c: cover property (@(negedge sck_clk) disable iff (ce_n) mode_reg == SFWC_OUT_STD);
  leg_out_c: cover property (@(negedge sck_clk) disable iff (ce_n)
    mode_reg == SFWC_OUT_LEG && out_byte_reg[0]);
endmodule

// File: rtl/sfwc_pkg.sv
// Purpose: shared constants and types for the serial flash write control and ident block
// Assumes: core clock of 40 MHz, serial link framed by an active-low chip enable
// Notes: opcodes that the block must match but whose value is free are module parameters
package sfwc_pkg;
  // Core clock and the longest byte program time it must cover
  localparam int CLK_PERIOD_NS = 25;
  localparam int BP_TIME_US = 10;
  // Longest time, so integer division rounds down
  localparam int BP_CYCLES = (BP_TIME_US * 1000) / CLK_PERIOD_NS;

  // Fixed opcodes
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STD_IDENT = 8'h9f;
  localparam logic [7:0] OP_LEG_IDENT_A = 8'h90;
  localparam logic [7:0] OP_LEG_IDENT_B = 8'hab;
  // Defaults for the parameterised opcodes
  localparam logic [7:0] OP_WRITE_ENABLE_DEF = 8'h06;
  localparam logic [7:0] OP_ARM_STATUS_DEF = 8'h50;
  localparam logic [7:0] OP_STATUS_WRITE_DEF = 8'h01;

  // Link bit counts: opcode, one data byte, 24 address bits
  localparam logic [5:0] CNT_OPCODE_LAST = 6'h07;
  localparam logic [5:0] CNT_DATA_LAST = 6'h0f;
  localparam logic [5:0] CNT_ADDR_LAST = 6'h1f;
  localparam logic [5:0] CNT_STD_START = 6'h08;
  localparam logic [5:0] CNT_LEG_START = 6'h20;
  localparam logic [5:0] CNT_STEP = 6'h01;

  // Field layout of the status write data byte
  localparam int SR_BP_LSB = 2;
  localparam int SR_BP_MSB = 5;
  localparam int SR_LOCK_POS = 7;

  // Legacy ident addresses
  localparam logic [23:0] ID_ADDR_MFR = 24'h000000;
  localparam logic [23:0] ID_ADDR_DEV = 24'h000001;

  // Output sequencer modes
  typedef enum logic [1:0] {
    SFWC_OUT_IDLE = 2'b00,
    SFWC_OUT_STD = 2'b01,
    SFWC_OUT_LEG = 2'b10
  } sfwc_out_t;

  // Status bits shown to the core
  typedef struct packed {
    logic lock;
    logic [3:0] protect;
    logic auto_inc;
    logic wel;
    logic busy;
  } sfwc_status_t;

  // Identification bytes
  typedef struct packed {
    logic [7:0] mfr;
    logic [7:0] mem_type;
    logic [7:0] capacity;
  } sfwc_ident_t;

  localparam logic [1:0] PIN_SYNC_RESET = 2'h3;

  function automatic logic sfwc_is_std(input logic [7:0] op);
    return op == OP_STD_IDENT;
  endfunction

  function automatic logic sfwc_is_legacy(input logic [7:0] op);
    return (op == OP_LEG_IDENT_A) || (op == OP_LEG_IDENT_B);
  endfunction
endpackage

// File: rtl/sfwc_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: inputs are levels, not pulses
// Notes: the first stage feeds only the second stage
`timescale 1ns/100ps
module sfwc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  if (WIDTH < 1) begin : g_chk
    $error("sfwc_sync width must be positive");
  end

  // Both stages reset to the idle level of the pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule

// File: rtl/sfwc_prog_timer.sv
// Purpose: busy timer for one internal byte program
// Assumes: start is a one-cycle pulse in the core domain
// Notes: a start while busy is ignored
`timescale 1ns/100ps
module sfwc_prog_timer #(
  parameter int CYCLES = 400
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;

  if (CYCLES < 1) begin : g_chk
    $error("sfwc_prog_timer needs at least one cycle");
  end

  // Load on start, count down to idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (start && (cnt_reg == '0)) begin
      cnt_reg <= CW'(CYCLES);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - CW'(1);
    end
  end

  assign busy = (cnt_reg != '0);
endmodule

// File: tb/sfwc_host.sv
// Purpose: SPI host model on the far side of the flash control block
// Assumes: mode 0, 64 ns serial clock, clock low outside frames
// Notes: idle data line toggles so a stale bit never passes for a real one
`timescale 1ns/100ps
module sfwc_host (
  output logic sck_clk,
  output logic ce_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  // Deselected and quiet from time zero
  initial begin
    sck_clk = 1'b0;
    ce_n = 1'b1;
    si = 1'b0;
  end

  // Send ntx bits, then clock nrx bits back; chip enable left low
  task automatic shift(input logic [31:0] tx, input int ntx, input int nrx,
                       output logic [31:0] rx, output logic oe_on);
    rx = '0;
    oe_on = 1'b1;
    ce_n = 1'b0;
    #100;
    for (int i = ntx - 1; i >= 0; i--) begin
      si = tx[i];
      #32 sck_clk = 1'b1;
      #32 sck_clk = 1'b0;
    end
    for (int i = 0; i < nrx; i++) begin
      si = ~si;
      #32 sck_clk = 1'b1;
      rx = {rx[30:0], so};
      oe_on = oe_on & so_oe;
      #32 sck_clk = 1'b0;
    end
  endtask

  // End the frame, see the output released, leave time to execute
  task automatic finish(output logic oe_off);
    #40 ce_n = 1'b1;
    si = ~si;
    #10 oe_off = so_oe;
    #290;
  endtask
endmodule

// File: tb/test_spi_flash_write_control_and_id.sv
// Purpose: self-checking bench for the flash write control and ident block
// Assumes: link driven by the host model, core inputs by this module
// Notes: program time shortened to 60 core cycles to keep the run short
`timescale 1ns/100ps
module test_spi_flash_write_control_and_id;
  import sfwc_pkg::*;
  localparam logic [7:0] OP_WE = 8'h16;
  localparam logic [7:0] OP_ARM = 8'h5e;
  localparam logic [7:0] OP_SW = 8'h11;
  localparam sfwc_ident_t ID = 24'h6e2d81; // Arbitrary values
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic prog_req = 1'b0;
  logic auto_inc_start = 1'b0;
  logic sck_clk;
  logic ce_n;
  logic si;
  logic so;
  logic so_oe;
  logic prog_grant;
  sfwc_status_t status;
  int fail_count = 0;
  int samples_checked = 0;
  logic e_lock = 1'b0;
  logic [3:0] e_prot = 4'h0;
  logic e_auto = 1'b0;
  logic e_wel = 1'b0;
  logic [31:0] rx;
  logic oe_on;
  logic oe_off;

  always #12.5 core_clk = ~core_clk;

  // Opcodes moved off their defaults to exercise the parameters
  sfwc_top #(.OP_WRITE_ENABLE(OP_WE), .OP_ARM_STATUS(OP_ARM), .OP_STATUS_WRITE(OP_SW),
    .IDENT(ID), .PROG_CYCLES(60)) u_sfwc_top (
    .core_clk(core_clk), .rst_n(rst_n), .sck_clk(sck_clk), .ce_n(ce_n), .si(si),
    .wp_n(wp_n), .prog_req(prog_req), .auto_inc_start(auto_inc_start), .so(so), .so_oe(so_oe),
    .prog_grant(prog_grant), .status(status));

  sfwc_host u_sfwc_host (.sck_clk(sck_clk), .ce_n(ce_n), .si(si), .so(so), .so_oe(so_oe));

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Status against the bench's own view of every bit
  task automatic chk_st(input string what);
    sfwc_status_t e;
    e = {e_lock, e_prot, e_auto, e_wel, 1'b0};
    samples_checked++;
    if (status !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, e, status);
    end
  endtask

  task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] got);
    samples_checked++;
    if (got !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, e, got);
    end
  endtask

  task automatic cmd(input logic [7:0] op);
    u_sfwc_host.shift({24'h0, op}, 8, 0, rx, oe_on);
    u_sfwc_host.finish(oe_off);
  endtask

  task automatic arm_write(input logic [7:0] d);
    cmd(OP_ARM);
    u_sfwc_host.shift({16'h0, OP_SW, d}, 16, 0, rx, oe_on);
    u_sfwc_host.finish(oe_off);
  endtask

  // Grant may land on the edge that takes the request or up to two edges after it
  task automatic req_prog(input logic exp);
    logic g;
    @(posedge core_clk) prog_req <= 1'b1;
    @(posedge core_clk) prog_req <= 1'b0;
    #1 g = prog_grant;
    repeat (2) begin
      @(posedge core_clk) #1 g = g | prog_grant;
    end
    chk_val("grant", {31'h0, exp}, {31'h0, g});
  endtask

  task automatic t_wel();
    req_prog(1'b0);
    u_sfwc_host.shift({24'h0, OP_WE}, 8, 0, rx, oe_on);
    #300 chk_st("latch while selected");
    u_sfwc_host.finish(oe_off);
    e_wel = 1'b1;
    chk_st("latch set");
    @(posedge core_clk) auto_inc_start <= 1'b1;
    @(posedge core_clk) auto_inc_start <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 e_auto = 1'b1;
    chk_st("auto increment set");
    cmd(OP_WRITE_DISABLE);
    e_wel = 1'b0;
    e_auto = 1'b0;
    chk_st("write disable");
  endtask

  task automatic t_prog();
    int n;
    cmd(OP_WE);
    req_prog(1'b1);
    chk_val("busy", 32'h1, {31'h0, status.busy});
    cmd(OP_WRITE_DISABLE);
    chk_val("busy after disable", 32'h1, {31'h0, status.busy});
    for (n = 0; n < 100 && status.busy !== 1'b0; n++) @(posedge core_clk);
    if (n == 100) begin
      fail_count++;
      close_out();
    end
    #1 chk_st("program done");
    req_prog(1'b0);
  endtask

  task automatic t_status();
    arm_write(8'h94);
    e_lock = 1'b1;
    e_prot = 4'h5;
    chk_st("armed write sets lock");
    arm_write(8'h28);
    e_lock = 1'b0;
    e_prot = 4'ha;
    chk_st("pin high clears lock");
    cmd(OP_ARM);
    cmd(OP_WRITE_DISABLE);
    u_sfwc_host.shift({16'h0, OP_SW, 8'h04}, 16, 0, rx, oe_on);
    u_sfwc_host.finish(oe_off);
    chk_st("arming lost");
    cmd(OP_WE);
    u_sfwc_host.shift({16'h0, OP_SW, 8'h0c}, 16, 0, rx, oe_on);
    u_sfwc_host.finish(oe_off);
    e_prot = 4'h3;
    chk_st("latch write clears latch");
    @(posedge core_clk) wp_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    arm_write(8'h9c);
    e_lock = 1'b1;
    e_prot = 4'h7;
    chk_st("pin low lock rises");
    arm_write(8'h00);
    chk_st("pin low locked");
    @(posedge core_clk) wp_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    arm_write(8'h00);
    e_lock = 1'b0;
    e_prot = 4'h0;
    chk_st("unlocked rewrite");
  endtask

  // Legacy ident with each opcode, read from the maker and the device address
  task automatic t_legacy();
    u_sfwc_host.shift({OP_LEG_IDENT_A, ID_ADDR_MFR}, 32, 32, rx, oe_on);
    u_sfwc_host.finish(oe_off);
    chk_val("legacy from maker", {ID.mfr, ID.capacity, ID.mfr, ID.capacity}, rx);
    chk_val("legacy drive", 32'h1, {31'h0, oe_on});
    u_sfwc_host.shift({OP_LEG_IDENT_B, ID_ADDR_DEV}, 32, 32, rx, oe_on);
    u_sfwc_host.finish(oe_off);
    chk_val("legacy from device", {ID.capacity, ID.mfr, ID.capacity, ID.mfr}, rx);
    chk_val("legacy release", 32'h0, {31'h0, oe_off});
  endtask

  task automatic t_std();
    u_sfwc_host.shift({24'h0, OP_STD_IDENT}, 8, 32, rx, oe_on);
    u_sfwc_host.finish(oe_off);
    chk_val("ident bytes", {ID, 8'h00}, rx);
    chk_val("ident drive", 32'h1, {31'h0, oe_on});
    u_sfwc_host.shift({24'h0, OP_STD_IDENT}, 8, 12, rx, oe_on);
    u_sfwc_host.finish(oe_off);
    chk_val("ident cut short", {20'h0, ID[23:12]}, rx);
    chk_val("ident release", 32'h0, {31'h0, oe_off});
    cmd(8'h00);
    chk_st("after no operation");
  endtask

  // Hang guard
  initial begin
    #200000;
    fail_count++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 chk_st("reset");
    chk_val("grant at reset", 32'h0, {31'h0, prog_grant});
    t_wel();
    t_prog();
    t_status();
    t_legacy();
    t_std();
    close_out();
  end
endmodule
